/* common/rsr_pkg.sv */
// constants, types and contract list for the relay settle and status registers
// Contract
// - busy stays asserted one microsecond per count held in the settle delay.
// - settle delay register is sixteen bits, zero to about 65 ms.
// - busy is visible to the host for polling, interrupt or trigger routing; the code only drives the busy_out port and no register reads it.
// - status bits 15..13 hold hardware revision; bits 12..1 read zero.
// - status bit 0 sets when front-panel interlock activates; zero at power-on.
// - any status read returns bit 0 then clears it; the code keeps it set when an interlock event arrives in the read cycle.
// - each relay register bit drives one relay: 1 closed, 0 open.
// - decode address as extended base plus module base plus offset.
// - bit 0 of relay register at offset 0 drives the first relay.
// - every relay register write raises busy; busy drops at delay timeout. With a zero delay the code leaves busy low.
// - settle delay register sits at offset 0x202, read and write.
package rsr_pkg;
  // ************************************************************
  // register map (byte offsets inside the module window)
  // ************************************************************
  localparam logic [31:0] RSR_WIN_BYTES = 32'h0000_0400;
  localparam logic [31:0] RSR_DLY_OFS = 32'h0000_0202;
  localparam logic [31:0] RSR_STAT_OFS = 32'h0000_0204;
  localparam int RSR_RELAY_REGS = 8;
  localparam logic [31:0] RSR_RELAY_END = 32'h0000_0010;
  localparam int RSR_IDX_W = 3;
  localparam logic [15:0] RSR_DLY_RST = 16'h0000;
  localparam logic [15:0] RSR_RELAY_RST = 16'h0000;

  // ************************************************************
  // status field layout
  // ************************************************************
  localparam int RSR_REV_HI = 15;
  localparam int RSR_REV_LO = 13;
  localparam int RSR_ILK_BIT = 0;
  localparam logic [2:0] RSR_HW_REV = 3'h1; // arbitrary value

  // ************************************************************
  // timing
  // ************************************************************
  localparam int RSR_CLK_NS = 50;
  localparam int RSR_TICK_NS = 1000;
  localparam int RSR_TICK_CYC = (RSR_TICK_NS + RSR_CLK_NS - 1) / RSR_CLK_NS;
  localparam logic [4:0] RSR_TICK_LAST = 5'(RSR_TICK_CYC - 1);

  // host register access, one cycle per request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [31:0] addr;
    logic [15:0] wdata;
  } rsr_bus_t;

  typedef logic [RSR_RELAY_REGS-1:0][15:0] rsr_relays_t;
endpackage

/* rtl/rsr_regs.sv */
// relay register bank with settle-delay busy timer and interlock status
`timescale 1ns/1ns
module rsr_regs (
  // clock and reset
  input wire logic ref_clk_in,
  input wire logic rst_in,
  // host register access
  input wire rsr_pkg::rsr_bus_t bus_in,
  input wire logic [31:0] ext_base_in,
  input wire logic [31:0] module_base_in,
  output logic [15:0] rdata_out,
  output logic rd_valid_out,
  // front panel and relay drivers
  input wire logic interlock_in,
  output rsr_pkg::rsr_relays_t relay_out,
  output logic busy_out
);
  import rsr_pkg::*;

  // ************************************************************
  // address decode
  // ************************************************************
  logic [31:0] offs;
  logic in_win;
  logic relay_hit;
  logic [RSR_IDX_W-1:0] relay_idx;
  logic relay_wr;
  logic dly_wr;
  logic stat_rd;
  logic [15:0] delay_reg;
  logic [15:0] remaining;
  logic [15:0] next_remaining;
  logic [4:0] presc;
  logic tick;
  logic ilk_s1;
  logic ilk_s2;
  logic ilk_s3;
  logic ilk_lvl;
  logic ilk_event;
  logic ilk_flag;

  // module window starts at extended base plus module base
  assign offs = bus_in.addr - (ext_base_in + module_base_in);
  assign in_win = offs < RSR_WIN_BYTES;
  assign relay_hit = in_win && (offs < RSR_RELAY_END) && !offs[0];
  assign relay_idx = offs[RSR_IDX_W:1];
  assign relay_wr = bus_in.wr && relay_hit;
  assign dly_wr = bus_in.wr && in_win && (offs == RSR_DLY_OFS);
  assign stat_rd = bus_in.rd && in_win && (offs == RSR_STAT_OFS);

  // ************************************************************
  // relay registers
  // ************************************************************
  // whole word replaces the register, so no read-modify-write is needed
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      relay_out <= {RSR_RELAY_REGS{RSR_RELAY_RST}};
    end else if (relay_wr) begin
      relay_out[relay_idx] <= bus_in.wdata;
    end
  end

  // ************************************************************
  // settle delay register and busy timer
  // ************************************************************
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      delay_reg <= RSR_DLY_RST;
    end else if (dly_wr) begin
      delay_reg <= bus_in.wdata;
    end
  end

  // microsecond prescaler restarts on each relay write so the first
  // count is a full microsecond, never a partial one
  assign tick = (presc == RSR_TICK_LAST);
  always_ff @(posedge ref_clk_in) begin
    if (rst_in || relay_wr || tick) begin
      presc <= '0;
    end else begin
      presc <= presc + 5'h01;
    end
  end

  // a relay write during the countdown reloads it
  always_comb begin
    next_remaining = remaining;
    if (relay_wr) begin
      next_remaining = delay_reg;
    end else if (tick && (remaining != 16'h0000)) begin
      next_remaining = remaining - 16'h0001;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      remaining <= 16'h0000;
      busy_out <= 1'b0;
    end else begin
      remaining <= next_remaining;
      busy_out <= (next_remaining != 16'h0000);
    end
  end

  // ************************************************************
  // interlock input and status flag
  // ************************************************************
  // three stages; an edge counts once the last two agree
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      ilk_s1 <= 1'b0;
      ilk_s2 <= 1'b0;
      ilk_s3 <= 1'b0;
      ilk_lvl <= 1'b0;
    end else begin
      ilk_s1 <= interlock_in;
      ilk_s2 <= ilk_s1;
      ilk_s3 <= ilk_s2;
      if (ilk_s2 == ilk_s3) begin
        ilk_lvl <= ilk_s3;
      end
    end
  end
  assign ilk_event = ilk_s2 && ilk_s3 && !ilk_lvl;

  // a new event in the read cycle wins so it is not lost
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      ilk_flag <= 1'b0;
    end else if (ilk_event) begin
      ilk_flag <= 1'b1;
    end else if (stat_rd) begin
      ilk_flag <= 1'b0;
    end
  end

  // ************************************************************
  // read data
  // ************************************************************
  // unmapped offsets read as zero
  always_ff @(posedge ref_clk_in) begin
    if (rst_in) begin
      rdata_out <= 16'h0000;
      rd_valid_out <= 1'b0;
    end else begin
      rd_valid_out <= bus_in.rd;
      rdata_out <= 16'h0000;
      if (bus_in.rd && relay_hit) begin
        rdata_out <= relay_out[relay_idx];
      end else if (bus_in.rd && in_win && (offs == RSR_DLY_OFS)) begin
        rdata_out <= delay_reg;
      end else if (stat_rd) begin
        rdata_out[RSR_REV_HI:RSR_REV_LO] <= RSR_HW_REV;
        rdata_out[RSR_ILK_BIT] <= ilk_flag;
      end
    end
  end

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (rst_in);

  sequence relay_write_one_s;
    relay_wr && (delay_reg == 16'h0001);
  endsequence

  sequence quiet_s;
    (!relay_wr) [*8];
  endsequence

  busy_raise_a: assert property (
    relay_wr && (delay_reg != 16'h0000) |=> busy_out)
    else $error("busy not raised after relay write");

  busy_zero_a: assert property (
    relay_wr && (delay_reg == 16'h0000) |=> !busy_out)
    else $error("busy raised with zero delay");

  busy_hold_a: assert property (
    relay_write_one_s ##1 quiet_s |-> busy_out)
    else $error("busy dropped before one microsecond");

  busy_end_a: assert property (
    busy_out && (remaining == 16'h0001) && tick && !relay_wr |=> !busy_out)
    else $error("busy held past timeout");

  flag_set_a: assert property (
    ilk_event |=> ilk_flag)
    else $error("interlock flag not set");

  status_clear_a: assert property (
    stat_rd && !ilk_event |=> !ilk_flag ##0 (rdata_out[RSR_ILK_BIT] == $past(ilk_flag)))
    else $error("status read did not return then clear flag");

  rev_field_a: assert property (
    stat_rd |=> (rdata_out[RSR_REV_HI:RSR_REV_LO] == RSR_HW_REV)
      && (rdata_out[RSR_REV_LO-1:RSR_ILK_BIT+1] == '0))
    else $error("status revision field wrong");

  relay_store_a: assert property (
    relay_wr && (relay_idx == '0) |=> relay_out[0] == $past(bus_in.wdata))
    else $error("first relay register not stored");

  delay_store_a: assert property (
    dly_wr |=> delay_reg == $past(bus_in.wdata))
    else $error("delay register not stored");

  window_decode_a: assert property (
    bus_in.wr && !in_win |=> $stable(relay_out) && $stable(delay_reg))
    else $error("write outside window took effect");

  busy_reload_a: assert property (
    relay_wr |=> remaining == $past(delay_reg))
    else $error("relay write did not reload the countdown");

  delay_read_a: assert property (
    bus_in.rd && in_win && (offs == RSR_DLY_OFS) |=> rd_valid_out && (rdata_out == $past(delay_reg)))
    else $error("delay register read back wrong");
endmodule // rsr_regs

/* sim/rsr_host.sv */
// host controller model issuing one-cycle register accesses
`timescale 1ns/1ns
module rsr_host #(
  parameter logic [31:0] BASE = 32'h0000_0000
) (
  // clock
  input wire logic ref_clk_in,
  // register access toward the device
  output rsr_pkg::rsr_bus_t bus_out
);
  import rsr_pkg::*;
  initial bus_out = '0;
  // one request per call; a released bus shows inverted values, never stale ones
  task automatic req(input logic w, input logic [31:0] ofs, input logic [15:0] d);
    @(negedge ref_clk_in);
    bus_out = '{wr: w, rd: !w, addr: BASE + ofs, wdata: d};
    @(negedge ref_clk_in);
    bus_out = '{wr: 1'b0, rd: 1'b0, addr: ~(BASE + ofs), wdata: ~d};
  endtask
endmodule // rsr_host

/* sim/tb_top.sv */
// self-checking bench for the relay settle and status registers
`timescale 1ns/1ns
module tb_top;
  import rsr_pkg::*;
  localparam logic [31:0] EXT = 32'h0020_0000;
  localparam logic [31:0] MOD = 32'h0000_0400;
  logic ref_clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic interlock_in = 1'b0;
  rsr_bus_t bus;
  logic [15:0] rdata;
  logic rd_valid;
  rsr_relays_t relay;
  logic busy_out;
  int n_fail = 0;
  int n_tests = 0;
  // 20 MHz clock
  always #25 ref_clk_in = ~ref_clk_in;
  rsr_host #(.BASE(EXT + MOD)) i_rsr_host (.ref_clk_in(ref_clk_in), .bus_out(bus));
  rsr_regs i_rsr_regs (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .bus_in(bus),
    .ext_base_in(EXT), .module_base_in(MOD), .rdata_out(rdata),
    .rd_valid_out(rd_valid), .interlock_in(interlock_in), .relay_out(relay),
    .busy_out(busy_out));
  // ************************************************************
  // shared tasks
  // ************************************************************
  task automatic test_done();
    if (n_fail == 0 && n_tests > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // read, then wait for the answer under a bound
  task automatic rd(input logic [31:0] ofs, input logic [15:0] exp);
    int n = 0;
    i_rsr_host.req(1'b0, ofs, 16'h0000);
    while (rd_valid !== 1'b1) begin
      n++;
      if (n > 4) begin
        n_fail++;
        test_done();
      end
      @(negedge ref_clk_in);
    end
    chk(rdata, exp);
  endtask
  // every relay register, then odd and out-of-window writes that must be ignored
  task automatic t_relay();
    for (int i = 0; i < RSR_RELAY_REGS; i++) begin
      i_rsr_host.req(1'b1, 32'(2 * i), 16'h0041 << i);
    end
    for (int i = 0; i < RSR_RELAY_REGS; i++) begin
      chk(relay[i], 16'h0041 << i);
    end
    i_rsr_host.req(1'b1, 32'h0000_0000, 16'h0001);
    chk(relay[0], 16'h0001);
    i_rsr_host.req(1'b1, 32'h0000_0003, 16'h0004);
    i_rsr_host.req(1'b1, 32'h0000_0400, 16'h0000);
    chk(relay[1], 16'h0082);
    chk(relay[0], 16'h0001);
    rd(32'h0000_0206, 16'h0000);
    rd(32'h0000_0002, 16'h0082);
    rd(32'h0000_0000, 16'h0001);
  endtask
  // flag set by the pin, survives a status write, cleared by a read
  task automatic t_ilk();
    rd(32'h0000_0204, {RSR_HW_REV, 13'h0000});
    interlock_in = 1'b1;
    repeat (6) @(negedge ref_clk_in);
    interlock_in = 1'b0;
    i_rsr_host.req(1'b1, 32'h0000_0204, 16'h0000);
    rd(32'h0000_0204, {RSR_HW_REV, 13'h0001});
    rd(32'h0000_0204, {RSR_HW_REV, 13'h0000});
  endtask
  // busy length for a given count, one microsecond a count
  task automatic t_busy(input logic [15:0] cnt);
    int n = 0;
    i_rsr_host.req(1'b1, 32'h0000_0202, cnt);
    rd(32'h0000_0202, cnt);
    i_rsr_host.req(1'b1, 32'h0000_0000, 16'h0041);
    while (busy_out === 1'b1 && n < 3000) begin
      n++;
      @(negedge ref_clk_in);
    end
    chk(16'(n), 16'(cnt * 20));
    if (n == 3000) begin
      n_fail++;
      test_done();
    end
  endtask
  // a relay write inside the countdown restarts it from the full count
  task automatic t_reload();
    int n = 0;
    i_rsr_host.req(1'b1, 32'h0000_0202, 16'h0002);
    i_rsr_host.req(1'b1, 32'h0000_0000, 16'h0041);
    repeat (10) @(negedge ref_clk_in);
    i_rsr_host.req(1'b1, 32'h0000_0002, 16'h0082);
    while (busy_out === 1'b1 && n < 3000) begin
      n++;
      @(negedge ref_clk_in);
    end
    chk(16'(n), 16'(2 * RSR_TICK_NS / RSR_CLK_NS));
    if (n == 3000) begin
      n_fail++;
      test_done();
    end
  endtask
  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    repeat (20) @(negedge ref_clk_in);
    rst_in = 1'b0;
    chk(16'(busy_out), 16'h0000);
    rd(32'h0000_0202, RSR_DLY_RST);
    t_relay();
    t_ilk();
    t_busy(16'h0003);
    t_busy(16'h0001);
    t_busy(16'h0000);
    t_reload();
    i_rsr_host.req(1'b1, 32'h0000_0202, 16'hffff);
    rd(32'h0000_0202, 16'hffff);
    test_done();
  end
endmodule // tb_top
